// [src/voltage_input_channel.v]
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "vin_channel_map.vh"

// ============================================================
// Overview of operation
// - The converter sample is a 16-bit code spanning 0 to 10 V, kept at full width until range scaling.
// - A new measurement is processed once every 100 ms.
// - The input word goes to the com unit every 6.5 ms regardless of the measurement pace.
// - The channel value is an unsigned integer with full range 0 to 65520 (0xfff0).
// - One 16-bit word carries the value and only its top 12 bits hold measurement data.
// - Low byte bits 0-3 are empty, bits 4-7 hold the lowest value bits, the high byte the upper eight.
// - There are no output bytes; the identifier is 0x50 and parameters start with 0x56 plus two bytes.
// - Bits 1-2 of the first parameter byte pick filter off, 100, 10 or 1 percent per second.
// - An enabled filter ramps the reported value linearly at a rate relative to the range span.
// - At 1 percent per second a 90 percent step takes 90 seconds to pass through.
// - Bits 0-4 of the second parameter byte pick 0-10, 0-5, 0-2 or 0-1 V; bits 5-7 are unused.
// - Configuration without parameters leaves the filter off and the 0-10 V range.
// - No line fault detection or reporting exists.
module voltage_input_channel #(
  parameter [31:0] PROC_CYCLES = `PROC_CYCLES,
  parameter [31:0] SEND_CYCLES = `SEND_CYCLES
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Converter pins
  input  wire [15:0] adc_data_i,
  input  wire        adc_strobe_i,
  // Configuration bytes from the com unit
  input  wire [7:0]  cfg_byte_i,
  input  wire        cfg_valid_i,
  // Input word and configuration status to the com unit
  output reg  [15:0] word_o,
  output reg         word_valid_o,
  output reg         cfg_ok_o
);

  // ============================================================
  // Parser states
  localparam [3:0] ST_ID  = 4'b0001;
  localparam [3:0] ST_HDR = 4'b0010;
  localparam [3:0] ST_D1  = 4'b0100;
  localparam [3:0] ST_D2  = 4'b1000;

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [1:0]  filt_q;
  reg  [1:0]  filt_d;
  reg  [4:0]  range_q;
  reg  [4:0]  range_d;
  reg         cfg_ok_d;
  reg  [15:0] sample_q;
  reg         strobe_prev_q;
  reg  [31:0] proc_cnt_q;
  reg         proc_tick_q;
  reg  [31:0] send_cnt_q;
  reg  [11:0] target_q;
  reg  [11:0] target_d;
  reg  [19:0] scaled;
  reg  [15:0] clamped;
  reg  [31:0] rd_data;
  reg         meas_valid_q;
  reg         filt_tick_q;
  wire [7:0]  param1_rst;
  wire [7:0]  param2_rst;
  wire        strobe_lvl;
  wire [11:0] filt_value;
  wire        wb_req;
  wire        wb_wr;

  // ============================================================
  // Converter strobe and sample capture
  pin_sync u_strobe_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (adc_strobe_i),
    .level_o (strobe_lvl)
  );

  // Data is settled long before the synchronised strobe edge arrives
  always @(posedge clk_i) begin
    if (rst_i) begin
      strobe_prev_q <= 1'b0;
      sample_q      <= 16'h0000;
    end else begin
      strobe_prev_q <= strobe_lvl;
      if (strobe_lvl && !strobe_prev_q) begin
        sample_q <= adc_data_i;
      end
    end
  end

  // ============================================================
  // Processing pace
  always @(posedge clk_i) begin
    if (rst_i) begin
      proc_cnt_q  <= 32'h00000000;
      proc_tick_q <= 1'b0;
    end else if (proc_cnt_q == PROC_CYCLES - 32'h00000001) begin
      proc_cnt_q  <= 32'h00000000;
      proc_tick_q <= 1'b1;
    end else begin
      proc_cnt_q  <= proc_cnt_q + 32'h00000001;
      proc_tick_q <= 1'b0;
    end
  end

  // ============================================================
  // Range scaling, saturating at the top of the selected span
  always @* begin
    case (range_q)
      `RANGE_5V: scaled = {4'h0, sample_q} * 20'h00002;
      `RANGE_2V: scaled = {4'h0, sample_q} * 20'h00005;
      `RANGE_1V: scaled = {4'h0, sample_q} * 20'h0000a;
      default:   scaled = {4'h0, sample_q};
    endcase
    clamped  = (scaled[19:16] != 4'h0) ? 16'hffff : scaled[15:0];
    target_d = clamped[15:4];
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      target_q     <= 12'h000;
      meas_valid_q <= 1'b0;
    end else if (proc_tick_q) begin
      target_q     <= target_d;
      meas_valid_q <= 1'b1;
    end
  end

  // Filter steps one cycle after the target so it never ramps toward a stale sample
  always @(posedge clk_i) begin
    if (rst_i) begin
      filt_tick_q <= 1'b0;
    end else begin
      filt_tick_q <= proc_tick_q;
    end
  end

  ramp_filter u_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (filt_tick_q),
    .mode_i   (filt_q),
    .target_i (target_q),
    .value_o  (filt_value)
  );

  // ============================================================
  // Cyclic word to the com unit
  always @(posedge clk_i) begin
    if (rst_i) begin
      send_cnt_q   <= 32'h00000000;
      word_o       <= 16'h0000;
      word_valid_o <= 1'b0;
    end else if (send_cnt_q == SEND_CYCLES - 32'h00000001) begin
      send_cnt_q   <= 32'h00000000;
      word_o       <= {filt_value, 4'h0};
      word_valid_o <= 1'b1;
    end else begin
      send_cnt_q   <= send_cnt_q + 32'h00000001;
      word_valid_o <= 1'b0;
    end
  end

  // ============================================================
  // Configuration parser and parameter store
  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr  = wb_req && we_i && (adr_i == `REG_PARAM);
  assign param1_rst = `PARAM1_RST;
  assign param2_rst = `PARAM2_RST;

  always @* begin
    state_d  = state_q;
    filt_d   = filt_q;
    range_d  = range_q;
    cfg_ok_d = cfg_ok_o;
    if (wb_wr) begin
      if (sel_i[0]) begin
        filt_d = dat_i[`FILT_MSB:`FILT_LSB];
      end
      if (sel_i[1]) begin
        range_d = dat_i[8+`RANGE_MSB:8+`RANGE_LSB];
      end
    end
    // The com unit stream wins over a software write in the same cycle
    if (cfg_valid_i) begin
      case (state_q)
        ST_ID: begin
          if (cfg_byte_i == `CFG_IDENT_CODE) begin
            cfg_ok_d = 1'b1;
            filt_d   = param1_rst[`FILT_MSB:`FILT_LSB];
            range_d  = param2_rst[`RANGE_MSB:`RANGE_LSB];
            state_d  = ST_HDR;
          end else begin
            cfg_ok_d = 1'b0;
          end
        end
        ST_HDR: begin
          if (cfg_byte_i == `CFG_HDR_CODE) begin
            state_d = ST_D1;
          end else if (cfg_byte_i == `CFG_IDENT_CODE) begin
            state_d = ST_HDR;
          end else begin
            cfg_ok_d = 1'b0;
            state_d  = ST_ID;
          end
        end
        ST_D1: begin
          filt_d  = cfg_byte_i[`FILT_MSB:`FILT_LSB];
          state_d = ST_D2;
        end
        ST_D2: begin
          range_d = cfg_byte_i[`RANGE_MSB:`RANGE_LSB];
          state_d = ST_ID;
        end
        default: begin
          state_d = ST_ID;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= ST_ID;
      filt_q   <= `FILT_OFF;
      range_q  <= `RANGE_10V;
      cfg_ok_o <= 1'b0;
    end else begin
      state_q  <= state_d;
      filt_q   <= filt_d;
      range_q  <= range_d;
      cfg_ok_o <= cfg_ok_d;
    end
  end

  // ============================================================
  // Wishbone slave: one registered answer in the cycle after the request, every address acknowledged
  always @* begin
    case (adr_i)
      `REG_PARAM:  rd_data = {19'h00000, range_q, 5'h00, filt_q, 1'b0};
      // No wiring fault bit exists in the status word
      `REG_STATUS: rd_data = {14'h0000, meas_valid_q, cfg_ok_o, filt_value, 4'h0};
      `REG_IDENT:  rd_data = {16'h0000, `CFG_HDR_CODE, `CFG_IDENT_CODE};
      `REG_WORD:   rd_data = {16'h0000, word_o};
      default:     rd_data = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      dat_o <= (wb_req && !we_i) ? rd_data : 32'h00000000;
    end
  end

endmodule // voltage_input_channel

// [src/vin_channel_map.vh]
`ifndef VIN_CHANNEL_MAP_VH
`define VIN_CHANNEL_MAP_VH

// ============================================================
// Clock and timing
// Counts built from the clock rate so no intermediate product leaves 32 bits
`define CLK_FREQ_MHZ        250
`define PROC_TIME_MS        100
`define PROC_CYCLES         (`PROC_TIME_MS * 1000 * `CLK_FREQ_MHZ)
`define SEND_TIME_US        6500
`define SEND_CYCLES         (`SEND_TIME_US * `CLK_FREQ_MHZ)

// ============================================================
// Register offsets (byte addresses)
`define REG_PARAM           8'h00
`define REG_STATUS          8'h04
`define REG_IDENT           8'h08
`define REG_WORD            8'h0c

// ============================================================
// Parameter fields
`define FILT_LSB            1
`define FILT_MSB            2
`define RANGE_LSB           0
`define RANGE_MSB           4
`define PARAM1_RST          8'h00
`define PARAM2_RST          8'h00

// ============================================================
// Configuration codes
`define CFG_IDENT_CODE      8'h50
`define CFG_HDR_CODE        8'h56

// ============================================================
// Filter modes and step per processing tick (12.8 fixed point)
`define FILT_OFF            2'h0
`define FILT_100            2'h1
`define FILT_10             2'h2
`define FILT_1              2'h3
`define STEP_100            20'h19980
`define STEP_10             20'h028f3
`define STEP_1              20'h00418

// ============================================================
// Range codes
`define RANGE_10V           5'h00
`define RANGE_5V            5'h01
`define RANGE_2V            5'h02
`define RANGE_1V            5'h03

`endif

// [src/pin_sync.v]
`timescale 1ns/100ps

// ============================================================
// Three-stage synchroniser; output moves once stages two and three agree
module pin_sync (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Pin and result
  input  wire pin_i,
  output wire level_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level_o = level_q;

endmodule // pin_sync

// [src/ramp_filter.v]
`timescale 1ns/100ps
`include "vin_channel_map.vh"

// ============================================================
// Linear ramp limiter, stepping once per processing tick
module ramp_filter (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Control
  input  wire        tick_i,
  input  wire [1:0]  mode_i,
  input  wire [11:0] target_i,
  // Result
  output wire [11:0] value_o
);

  reg  [19:0] acc_q;
  reg  [19:0] acc_d;
  reg  [19:0] step;
  wire [19:0] goal = {target_i, 8'h00};

  always @* begin
    case (mode_i)
      `FILT_100: step = `STEP_100;
      `FILT_10:  step = `STEP_10;
      default:   step = `STEP_1;
    endcase
    acc_d = acc_q;
    if (tick_i) begin
      if (mode_i == `FILT_OFF) begin
        acc_d = goal;
      end else if (goal > acc_q) begin
        acc_d = ((goal - acc_q) > step) ? acc_q + step : goal;
      end else begin
        acc_d = ((acc_q - goal) > step) ? acc_q - step : goal;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 20'h00000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Truncation keeps the ramp exact; rounding would overshoot by one LSB
  assign value_o = acc_q[19:8];

endmodule // ramp_filter

// [sim/vin_channel_monitor.sv]
`timescale 1ns/100ps
// ============================================================
// Port checker for the voltage input channel
module vin_channel_checker #(
  parameter [31:0] PROC_CYCLES = 32'd20,
  parameter [31:0] SEND_CYCLES = 32'd13
) (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Wishbone slave
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // Converter, configuration and word
  input wire [15:0] adc_data_i,
  input wire        adc_strobe_i,
  input wire [7:0]  cfg_byte_i,
  input wire        cfg_valid_i,
  input wire [15:0] word_o,
  input wire        word_valid_o,
  input wire        cfg_ok_o
);
  // Gap counter; the first word after reset has no reference
  logic [31:0] gap_q;
  logic        seen_q;
  always @(posedge clk_i) begin
    gap_q <= (rst_i || word_valid_o) ? 32'h0 : gap_q + 32'h1;
    seen_q <= !rst_i && (seen_q || word_valid_o);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; ack_o |=> !ack_o; endproperty
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  property p_word_pad; word_valid_o |-> word_o[3:0] == 4'h0; endproperty
  property p_word_gap; word_valid_o && seen_q |-> gap_q == SEND_CYCLES - 32'h1; endproperty
  property p_word_hold; !word_valid_o |-> $stable(word_o); endproperty
  property p_ident_ok; cfg_valid_i && cfg_byte_i == 8'h50 |=> cfg_ok_o; endproperty
  property p_ident_bad; cfg_valid_i && cfg_byte_i != 8'h50 && !cfg_ok_o |=> !cfg_ok_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_word_pad: assert property (p_word_pad) else $error("low nibble of word not empty");
  a_word_gap: assert property (p_word_gap) else $error("word period wrong");
  a_word_hold: assert property (p_word_hold) else $error("word changed without valid");
  a_ident_ok: assert property (p_ident_ok) else $error("identifier not accepted");
  a_ident_bad: assert property (p_ident_bad) else $error("wrong identifier accepted");
  c_word: cover property (word_valid_o && seen_q);
  c_ident: cover property (cfg_valid_i && cfg_byte_i == 8'h50);
  c_write: cover property (ack_o && we_i);
endmodule // vin_channel_checker

bind voltage_input_channel vin_channel_checker #(.PROC_CYCLES(PROC_CYCLES), .SEND_CYCLES(SEND_CYCLES))
  vin_channel_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .adc_data_i(adc_data_i),
  .adc_strobe_i(adc_strobe_i), .cfg_byte_i(cfg_byte_i), .cfg_valid_i(cfg_valid_i), .word_o(word_o),
  .word_valid_o(word_valid_o), .cfg_ok_o(cfg_ok_o));

// [sim/com_unit_model.sv]
`timescale 1ns/100ps
// ============================================================
// Com unit: sends configuration bytes, collects input words
module com_unit_model (
  // Clock
  input  wire        clk_i,
  // Input word from the channel
  input  wire [15:0] word_i,
  input  wire        word_valid_i,
  // Configuration stream
  output logic [7:0] cfg_byte_o = 8'h00,
  output logic       cfg_valid_o = 1'b0
);
  logic [15:0] last_word = 16'h0;
  int          words = 0;
  always @(posedge clk_i) begin
    if (word_valid_i) begin
      last_word <= word_i;
      words <= words + 1;
    end
  end
  task automatic put(input logic [7:0] b);
    @(posedge clk_i);
    cfg_byte_o <= b;
    cfg_valid_o <= 1'b1;
    @(posedge clk_i);
    cfg_valid_o <= 1'b0;
    // Inverted so a stale byte is never mistaken for a fresh one
    cfg_byte_o <= ~b;
  endtask
  task automatic cfg(input logic [7:0] d1, input logic [7:0] d2);
    put(8'h50);
    put(8'h56);
    put(d1);
    put(d2);
  endtask
endmodule // com_unit_model

// [sim/voltage_input_channel_readout_tb_top.sv]
`timescale 1ns/100ps
// ============================================================
// Bench for the voltage input channel
module voltage_input_channel_readout_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [15:0] adc_data_i = 16'h0;
  logic        adc_strobe_i = 1'b0;
  wire  [31:0] dat_o;
  wire         ack_o, word_valid_o, cfg_ok_o, cfg_valid;
  wire  [15:0] word_o;
  wire  [7:0]  cfg_byte;
  logic [31:0] rd;
  logic [2:0]  i;
  logic [11:0] tbl [4] = '{12'h199, 12'h333, 12'h7ff, 12'hfff};
  int          n_errors = 0;
  int          checked = 0;
  int          w0;
  always #2 clk_i = ~clk_i;
  voltage_input_channel #(.PROC_CYCLES(32'd20), .SEND_CYCLES(32'd13)) voltage_input_channel_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .adc_data_i(adc_data_i), .adc_strobe_i(adc_strobe_i),
    .cfg_byte_i(cfg_byte), .cfg_valid_i(cfg_valid), .word_o(word_o), .word_valid_o(word_valid_o),
    .cfg_ok_o(cfg_ok_o));
  com_unit_model com_unit_model_inst (.clk_i(clk_i), .word_i(word_o), .word_valid_i(word_valid_o),
    .cfg_byte_o(cfg_byte), .cfg_valid_o(cfg_valid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) n_errors++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Data is settled one cycle before the strobe edge
  task automatic adc(input logic [15:0] v, input int wait_n);
    @(posedge clk_i);
    adc_data_i <= v;
    @(posedge clk_i);
    adc_strobe_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    adc_strobe_i <= 1'b0;
    repeat (wait_n) @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h5650);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, 8'h00, {29'h0, i[1:0], 1'b0});
      wb(1'b0, 8'h00, 32'h0);
      chk({30'h0, rd[2:1]}, {30'h0, i[1:0]});
    end
    com_unit_model_inst.cfg(8'hf9, 8'he0);
    chk({31'h0, cfg_ok_o}, 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 4; i++) begin
      com_unit_model_inst.cfg(8'h00, {6'h0, i[1:0]});
      adc(16'h1999, 64);
      chk({16'h0, com_unit_model_inst.last_word}, {16'h0, tbl[i[1:0]], 4'h0});
    end
    adc(16'h2000, 64);
    chk({16'h0, com_unit_model_inst.last_word}, 32'h0000fff0);
    com_unit_model_inst.cfg(8'h00, 8'h00);
    adc(16'h0000, 64);
    chk({16'h0, com_unit_model_inst.last_word}, 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    adc(16'hffff, 40);
    wb(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[15:4] != 12'hfff}, 32'h1);
    repeat (240) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk({20'h0, rd[15:4]}, 32'h00000fff);
    chk({rd[31:16], 16'h0}, 32'h00030000);
    w0 = com_unit_model_inst.words;
    repeat (130) @(posedge clk_i);
    chk(com_unit_model_inst.words - w0, 32'd10);
    // At 10 %/s one or two steps fit here; 1 %/s stays above fe0, 100 %/s falls below f00
    wb(1'b1, 8'h00, 32'h4);
    adc(16'h0000, 40);
    wb(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[15:4] > 12'hf00 && rd[15:4] < 12'hfe0}, 32'h1);
    com_unit_model_inst.put(8'h50);
    com_unit_model_inst.put(8'h51);
    @(posedge clk_i);
    chk({31'h0, cfg_ok_o}, 32'h0);
    com_unit_model_inst.put(8'h51);
    @(posedge clk_i);
    chk({31'h0, cfg_ok_o}, 32'h0);
    print_verdict();
  end
endmodule // voltage_input_channel_readout_tb_top
